/* rtl/can_mode_pkg.sv */
// Package with mode encodings, carriers and timing constants for the transceiver mode control
package can_mode_pkg;
   // Transceiver mode field encoding
   localparam logic [1:0] TRX_OFF = 2'h0;
   localparam logic [1:0] TRX_WAKE_CAP = 2'h1;
   localparam logic [1:0] TRX_RX_ONLY = 2'h2;
   localparam logic [1:0] TRX_NORMAL = 2'h3;
   localparam logic [1:0] TRX_MODE_RESET = TRX_OFF;
   // Chip operating modes
   typedef enum logic [2:0] {
      CHIP_NORMAL, CHIP_STOP, CHIP_SLEEP, CHIP_RESTART, CHIP_FAILSAFE
   } chip_mode_t;
   // Timing
   localparam int CLK_PERIOD_NS = 50;
   localparam int ENABLE_DELAY_NS = 20000;
   localparam int ENABLE_DELAY_CYC = (ENABLE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WAKE_MIN_NS = 500;
   localparam int WAKE_MIN_CYC = (WAKE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WAKE_MAX_NS = 1800;
   localparam int WAKE_MAX_CYC = WAKE_MAX_NS / CLK_PERIOD_NS;
   localparam int CNT_W = 10;
   // Mode request from the SPI command decoder
   typedef struct packed {
      logic valid;
      logic [1:0] mode;
   } mode_req_t;
   // Bus side carrier
   typedef struct packed {
      logic drv_en;
      logic dominant;
   } bus_drive_t;
endpackage

/* rtl/can_transceiver_mode_ctrl.sv */
// Transceiver mode control, transmit gating and receive path of the CAN FD transceiver
`timescale 1ns/1ps
`default_nettype none
module can_transceiver_mode_ctrl (
   input wire logic ref_clk,
   input wire logic rst,
   input wire can_mode_pkg::mode_req_t mode_req,
   input wire can_mode_pkg::chip_mode_t chip_mode,
   input wire logic tx_data_in,
   input wire logic bus_rx_dom,
   output logic rx_data_out,
   output can_mode_pkg::bus_drive_t bus_drive,
   output logic [1:0] trx_mode,
   output logic tx_ready,
   output logic wake_event
);
   import can_mode_pkg::*;
   localparam logic [CNT_W+4:0] EN_C = (CNT_W+5)'(ENABLE_DELAY_CYC);

   logic [2:0] txs_r, rxs_r;
   logic tx_s, rx_dom_s;
   logic [1:0] mode_r, mode_nxt;
   logic [CNT_W+4:0] en_cnt_r, en_cnt_nxt;
   logic armed_r, armed_nxt;
   logic woke_r, woke_nxt;
   logic blk_r, blk_nxt;
   logic rx_nxt;
   bus_drive_t drv_nxt;
   logic rdy_nxt;
   logic wk_nxt;
   logic wake_det;
   logic tx_ok;
   logic fs_entry;
   chip_mode_t chip_prev_r;

   // Pin synchronisers, change taken when stages two and three agree
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         txs_r <= 3'h7;
         rxs_r <= 3'h0;
         tx_s <= 1'b1;
         rx_dom_s <= 1'b0;
      end else begin
         txs_r <= {txs_r[1:0], tx_data_in};
         rxs_r <= {rxs_r[1:0], bus_rx_dom};
         if (txs_r[1] == txs_r[2]) begin
            tx_s <= txs_r[2];
         end
         if (rxs_r[1] == rxs_r[2]) begin
            rx_dom_s <= rxs_r[2];
         end
      end
   end

   wake_pattern_det u_wake (
      .ref_clk(ref_clk),
      .rst(rst),
      .arm(armed_r),
      .bus_dom(rx_dom_s),
      .wake(wake_det)
   );

   assign tx_ok = (mode_r == TRX_NORMAL) && (en_cnt_r == EN_C);
   assign fs_entry = (chip_mode == CHIP_FAILSAFE) && (chip_prev_r != CHIP_FAILSAFE);

   always_comb begin
      mode_nxt = mode_r;
      en_cnt_nxt = en_cnt_r;
      armed_nxt = armed_r;
      woke_nxt = woke_r;
      blk_nxt = blk_r;
      wk_nxt = 1'b0;
      if (mode_req.valid) begin
         case (mode_req.mode)
            TRX_OFF: mode_nxt = TRX_OFF;
            TRX_NORMAL: begin
               if (chip_mode == CHIP_NORMAL) begin
                  mode_nxt = TRX_NORMAL;
               end
            end
            TRX_RX_ONLY: begin
               if (chip_mode == CHIP_NORMAL || chip_mode == CHIP_STOP) begin
                  mode_nxt = TRX_RX_ONLY;
               end
            end
            TRX_WAKE_CAP: begin
               if (chip_mode != CHIP_FAILSAFE) begin
                  mode_nxt = TRX_WAKE_CAP;
               end
            end
            default: mode_nxt = mode_r;
         endcase
      end
      // Fail-safe entry forces wake-capable once, so off stays selectable there
      if (fs_entry) begin
         mode_nxt = TRX_WAKE_CAP;
      end else if (mode_nxt == TRX_NORMAL && chip_mode != CHIP_NORMAL) begin
         mode_nxt = TRX_WAKE_CAP;
      end
      // Restart timer and arm blocking on each entry to normal
      if (mode_nxt == TRX_NORMAL && mode_r != TRX_NORMAL) begin
         en_cnt_nxt = '0;
         blk_nxt = 1'b1;
      end else if (mode_r == TRX_NORMAL && en_cnt_r != EN_C) begin
         en_cnt_nxt = en_cnt_r + 1'b1;
      end
      // Pending dominant suppressed until a recessive level is seen after the enable delay has run out
      if (tx_ok && tx_s) begin
         blk_nxt = 1'b0;
      end
      // Wake arming: set on a change to wake-capable, cleared on any other mode change, rearmed by chip low-power entry
      if (mode_nxt != mode_r) begin
         woke_nxt = 1'b0;
         armed_nxt = (mode_nxt == TRX_WAKE_CAP);
      end else if (wake_det && armed_r && mode_r == TRX_WAKE_CAP) begin
         woke_nxt = 1'b1;
         armed_nxt = 1'b0;
         wk_nxt = 1'b1;
      end else if (chip_mode != chip_prev_r &&
                   (chip_mode == CHIP_STOP || chip_mode == CHIP_SLEEP ||
                    chip_mode == CHIP_FAILSAFE) && mode_r == TRX_WAKE_CAP) begin
         armed_nxt = 1'b1;
         woke_nxt = 1'b0;
      end
      if (mode_nxt == TRX_OFF) begin
         armed_nxt = 1'b0;
         wk_nxt = 1'b0;
      end
      drv_nxt.drv_en = (mode_nxt == TRX_NORMAL);
      drv_nxt.dominant = tx_ok && !blk_nxt && !tx_s && (mode_nxt == TRX_NORMAL);
      rdy_nxt = (mode_nxt == TRX_NORMAL) && (en_cnt_nxt == EN_C);
      if (woke_nxt) begin
         rx_nxt = 1'b0;
      end else if (mode_nxt == TRX_NORMAL || mode_nxt == TRX_RX_ONLY) begin
         rx_nxt = !rx_dom_s;
      end else begin
         rx_nxt = 1'b1;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         mode_r <= TRX_MODE_RESET;
         en_cnt_r <= '0;
         armed_r <= 1'b0;
         woke_r <= 1'b0;
         blk_r <= 1'b1;
         chip_prev_r <= CHIP_NORMAL;
         bus_drive <= '0;
         rx_data_out <= 1'b1;
         trx_mode <= TRX_MODE_RESET;
         tx_ready <= 1'b0;
         wake_event <= 1'b0;
      end else begin
         mode_r <= mode_nxt;
         en_cnt_r <= en_cnt_nxt;
         armed_r <= armed_nxt;
         woke_r <= woke_nxt;
         blk_r <= blk_nxt;
         chip_prev_r <= chip_mode;
         bus_drive <= drv_nxt;
         rx_data_out <= rx_nxt;
         trx_mode <= mode_nxt;
         tx_ready <= rdy_nxt;
         wake_event <= wk_nxt;
      end
   end

   AST_OFF_NO_DRIVE: assert property (@(posedge ref_clk) disable iff (rst)
      trx_mode != TRX_NORMAL |-> !bus_drive.drv_en && !bus_drive.dominant)
      else $error("driver active outside normal mode");
   AST_OFF_NO_WAKE: assert property (@(posedge ref_clk) disable iff (rst)
      mode_r == TRX_OFF |=> !wake_event)
      else $error("wake signalled in off mode");
   AST_NORMAL_CHIP: assert property (@(posedge ref_clk) disable iff (rst)
      $rose(trx_mode == TRX_NORMAL) |-> $past(chip_mode) == CHIP_NORMAL)
      else $error("normal entered outside chip normal");
   AST_TX_FOLLOW: assert property (@(posedge ref_clk) disable iff (rst)
      bus_drive.dominant |-> trx_mode == TRX_NORMAL && $past(tx_s) == 1'b0)
      else $error("dominant without low transmit input");
   AST_EN_DELAY: assert property (@(posedge ref_clk) disable iff (rst)
      $rose(trx_mode == TRX_NORMAL) |-> !bus_drive.dominant [*8])
      else $error("dominant inside enable delay");
   AST_PENDING_SUPPRESS: assert property (@(posedge ref_clk) disable iff (rst)
      blk_r && !tx_s |=> !bus_drive.dominant)
      else $error("pending dominant not suppressed");
   AST_RX_FOLLOW: assert property (@(posedge ref_clk) disable iff (rst)
      trx_mode == TRX_RX_ONLY && !woke_r && $stable(trx_mode) |->
      rx_data_out == !$past(rx_dom_s))
      else $error("receive level not passed on");
   AST_WAKE_LOW: assert property (@(posedge ref_clk) disable iff (rst)
      wake_event |-> (rx_data_out == 1'b0) && trx_mode == TRX_WAKE_CAP)
      else $error("wake without low receive output");
   AST_WAKE_HOLD: assert property (@(posedge ref_clk) disable iff (rst)
      woke_r && $stable(trx_mode) |-> !rx_data_out)
      else $error("receive output released while woken");
   AST_RXONLY_NODRV: assert property (@(posedge ref_clk) disable iff (rst)
      trx_mode == TRX_RX_ONLY |-> !bus_drive.drv_en)
      else $error("driver on in receive-only");
   AST_EN_DONE: assert property (@(posedge ref_clk) disable iff (rst)
      bus_drive.dominant |-> $past(tx_ok))
      else $error("dominant before enable delay end");
   AST_OFF_ANY: assert property (@(posedge ref_clk) disable iff (rst)
      mode_req.valid && mode_req.mode == TRX_OFF && !fs_entry |=> trx_mode == TRX_OFF)
      else $error("off request not taken");
   COV_NORMAL_TX: cover property (@(posedge ref_clk) disable iff (rst) bus_drive.dominant);
   COV_FS_ENTRY: cover property (@(posedge ref_clk) disable iff (rst) fs_entry);
   COV_WAKE: cover property (@(posedge ref_clk) disable iff (rst) wake_event);
   COV_RXONLY: cover property (@(posedge ref_clk) disable iff (rst)
      trx_mode == TRX_RX_ONLY && !rx_data_out);
endmodule
`default_nettype wire

/* rtl/wake_pattern_det.sv */
// Wake-up pattern detector on the synchronised bus receive level
`timescale 1ns/1ps
`default_nettype none
module wake_pattern_det (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic arm,
   input wire logic bus_dom,
   output logic wake
);
   import can_mode_pkg::*;
   typedef enum logic [2:0] {W_IDLE, W_DOM1, W_REC, W_DOM2, W_DONE} wstate_t;
   wstate_t st_r, st_nxt;
   logic [CNT_W-1:0] cnt_r, cnt_nxt;
   logic prev_r, prev_nxt;
   logic wake_nxt;
   localparam logic [CNT_W-1:0] MIN_C = CNT_W'(WAKE_MIN_CYC);
   localparam logic [CNT_W-1:0] MAX_C = CNT_W'(WAKE_MAX_CYC);

   always_comb begin
      st_nxt = st_r;
      cnt_nxt = (cnt_r == MAX_C) ? cnt_r : cnt_r + 1'b1;
      prev_nxt = bus_dom;
      wake_nxt = 1'b0;
      if (bus_dom != prev_r) begin
         cnt_nxt = '0;
      end
      case (st_r)
         W_IDLE: begin
            if (bus_dom && !prev_r) begin
               st_nxt = W_DOM1;
            end
         end
         W_DOM1, W_DOM2: begin
            if (!bus_dom) begin
               if (cnt_r >= MIN_C && cnt_r < MAX_C) begin
                  st_nxt = (st_r == W_DOM1) ? W_REC : W_DONE;
               end else begin
                  st_nxt = W_IDLE;
               end
            end else if (cnt_r == MAX_C) begin
               st_nxt = W_IDLE;
            end
         end
         W_REC: begin
            if (bus_dom) begin
               st_nxt = (cnt_r >= MIN_C && cnt_r < MAX_C) ? W_DOM2 : W_DOM1;
            end else if (cnt_r == MAX_C) begin
               st_nxt = W_IDLE;
            end
         end
         W_DONE: begin
            wake_nxt = 1'b1;
            st_nxt = W_IDLE;
         end
         default: st_nxt = W_IDLE;
      endcase
      if (!arm) begin
         st_nxt = W_IDLE;
         wake_nxt = 1'b0;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         st_r <= W_IDLE;
         cnt_r <= '0;
         prev_r <= 1'b0;
         wake <= 1'b0;
      end else begin
         st_r <= st_nxt;
         cnt_r <= cnt_nxt;
         prev_r <= prev_nxt;
         wake <= wake_nxt;
      end
   end
endmodule
`default_nettype wire

/* tb/can_transceiver_mode_ctrl_tb.sv */
// Testbench of the transceiver mode control against a mode model
`timescale 1ns/1ps
`default_nettype none
module can_transceiver_mode_ctrl_tb;
   import can_mode_pkg::*;
   logic ref_clk, rst, tx_data_in, bus_rx_dom, rx_data_out, tx_ready, wake_event, early, tx_bit;
   logic start;
   mode_req_t mode_req;
   chip_mode_t chip_mode;
   bus_drive_t bus_drive;
   logic [1:0] trx_mode;
   int mismatches, check_count, exp_mode, wakes, seed, i, k;
   chip_mode_t cm_q[$] = '{CHIP_NORMAL, CHIP_STOP, CHIP_SLEEP, CHIP_RESTART};
   assign start = mode_req.valid && (mode_req.mode == TRX_NORMAL) && (chip_mode == CHIP_NORMAL);
   can_transceiver_mode_ctrl i_dut (.ref_clk, .rst, .mode_req, .chip_mode, .tx_data_in,
      .bus_rx_dom, .rx_data_out, .bus_drive, .trx_mode, .tx_ready, .wake_event);
   host_can_ctrl i_host (.ref_clk, .rst, .start, .early, .tx_bit, .tx_data_in);
   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) if (wake_event === 1'b1) wakes++;
   task automatic test_done;
      $display("checks=%0d mismatches=%0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input logic [3:0] got, input logic [3:0] exp);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   // Driver enable and mode field against the model, receive output against the given level
   task automatic chk_state(input logic rx);
      chk({bus_drive.drv_en, rx_data_out, trx_mode}, {exp_mode == TRX_NORMAL, rx, 2'(exp_mode)});
   endtask
   task automatic req(input logic [1:0] md);
      @(posedge ref_clk);
      mode_req <= '{valid: 1'b1, mode: md};
      @(posedge ref_clk);
      mode_req <= '0;
      if (!((md == TRX_NORMAL && chip_mode != CHIP_NORMAL) ||
            (md == TRX_RX_ONLY && !(chip_mode inside {CHIP_NORMAL, CHIP_STOP})) ||
            (md == TRX_WAKE_CAP && chip_mode == CHIP_FAILSAFE))) exp_mode = md;
      #1;
      chk_state(1'b1);
   endtask
   task automatic set_chip(input chip_mode_t c);
      @(posedge ref_clk);
      if (c == CHIP_FAILSAFE && chip_mode != CHIP_FAILSAFE) exp_mode = TRX_WAKE_CAP;
      chip_mode <= c;
      if (c != CHIP_NORMAL && exp_mode == TRX_NORMAL) exp_mode = TRX_WAKE_CAP;
      tick(3);
      chk_state(1'b1);
   endtask
   // Two dominant and two recessive phases of 20 cycles each
   task automatic wake_pat;
      for (i = 0; i < 4; i++) begin
         @(posedge ref_clk);
         bus_rx_dom <= ~i[0];
         tick(19);
      end
   endtask
   task automatic wait_ready;
      for (k = 0; k < 600 && tx_ready !== 1'b1; k++) tick(1);
      chk(4'(k == ENABLE_DELAY_CYC), 4'h1);
   endtask
   initial begin
      #(20000 * 50);
      mismatches++;
      test_done();
   end
   initial begin
      seed = 32'h8FF291E3;
      rst = 1'b1;
      mode_req = '0;
      chip_mode = CHIP_NORMAL;
      bus_rx_dom = 1'b0;
      early = 1'b0;
      tx_bit = 1'b1;
      exp_mode = TRX_MODE_RESET;
      tick(2);
      chk_state(1'b1);
      @(posedge ref_clk);
      rst <= 1'b0;
      for (i = 0; i < 40; i++) begin
         k = $random(seed);
         if (k[2]) set_chip(cm_q[k[1:0]]);
         else req(k[1:0]);
      end
      set_chip(CHIP_STOP);
      req(TRX_RX_ONLY);
      @(posedge ref_clk);
      bus_rx_dom <= 1'b1;
      tick(8);
      chk_state(1'b0);
      @(posedge ref_clk);
      bus_rx_dom <= 1'b0;
      tick(8);
      chk_state(1'b1);
      set_chip(CHIP_NORMAL);
      req(TRX_OFF);
      wakes = 0;
      wake_pat();
      chk({3'h0, rx_data_out}, 4'(1 + 2 * wakes));
      req(TRX_WAKE_CAP);
      wakes = 0;
      wake_pat();
      tick(20);
      chk({wakes[1:0], rx_data_out, trx_mode == TRX_WAKE_CAP}, 4'h5);
      req(TRX_OFF);
      set_chip(CHIP_FAILSAFE);
      req(TRX_OFF);
      set_chip(CHIP_NORMAL);
      early = 1'b1;
      tx_bit = 1'b0;
      req(TRX_NORMAL);
      wait_ready();
      tick(3);
      chk({3'h0, bus_drive.dominant}, 4'h0);
      for (k = 0; k < 30 && bus_drive.dominant !== 1'b1; k++) tick(1);
      chk(4'(k < 30), 4'h1);
      @(posedge ref_clk);
      tx_bit <= 1'b1;
      tick(8);
      chk({3'h0, bus_drive.dominant}, 4'h0);
      set_chip(CHIP_STOP);
      set_chip(CHIP_NORMAL);
      early = 1'b0;
      req(TRX_NORMAL);
      chk({3'h0, tx_ready}, 4'h0);
      wait_ready();
      test_done();
   end
endmodule
`default_nettype wire

/* tb/host_can_ctrl.sv */
// Model of the host protocol controller driving the transmit input
`timescale 1ns/1ps
`default_nettype none
module host_can_ctrl (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic start,
   input wire logic early,
   input wire logic tx_bit,
   output logic tx_data_in
);
   import can_mode_pkg::*;
   int cnt;
   // Waits out the enable delay with margin, dominant while early is set except the last 6 cycles, then sends tx_bit
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cnt <= 0;
         tx_data_in <= 1'b1;
      end else if (start) begin
         cnt <= ENABLE_DELAY_CYC + 12;
         tx_data_in <= 1'b1;
      end else if (cnt > 0) begin
         cnt <= cnt - 1;
         tx_data_in <= (cnt > 6) ? ~early : 1'b1;
      end else begin
         tx_data_in <= tx_bit;
      end
   end
endmodule
`default_nettype wire
